// File: sip_top.sv
// interrupt enables and spectral persistence filter
`timescale 1ns/1ps
module sip_top
(
  input  wire logic                                         clock,
  input  wire logic                                         arst_n,
  input  wire logic                                         reg_write,
  input  wire logic [7:0]                                   reg_addr,
  input  wire logic [7:0]                                   reg_wdata,
  output logic      [7:0]                                   reg_rdata,
  input  wire logic                                         flicker_status_change,
  input  wire logic                                         switch_matrix_done,
  input  wire logic                                         spectral_cycle_end,
  input  wire logic [sip_pkg::SIP_CHANNELS*sip_pkg::SIP_DATA_W-1:0] spectral_data,
  input  wire logic [sip_pkg::SIP_SEL_W-1:0]                threshold_channel_select,
  input  wire logic [sip_pkg::SIP_DATA_W-1:0]               spectral_low_threshold,
  input  wire logic [sip_pkg::SIP_DATA_W-1:0]               spectral_high_threshold,
  output logic                                              system_irq,
  output logic                                              spectral_irq,
  output logic [sip_pkg::SIP_COUNT_W-1:0]                   persistence_count
);
  import sip_pkg::*;

  // reset release synchroniser; first stage feeds only the second
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rst_n = rst_sync_reg;

  // register file state
  logic       flicker_status_irq_enable_reg;
  logic       flicker_status_irq_enable_next;
  logic       switch_matrix_done_irq_enable_reg;
  logic       switch_matrix_done_irq_enable_next;
  logic [3:0] persistence_count_code_reg;
  logic [3:0] persistence_count_code_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // writes store the fields; reserved bits read as zero
  always_comb
  begin
    flicker_status_irq_enable_next     = flicker_status_irq_enable_reg;
    switch_matrix_done_irq_enable_next = switch_matrix_done_irq_enable_reg;
    persistence_count_code_next        = persistence_count_code_reg;
    if (reg_write && reg_addr == SIP_ADDR_ENABLES)
    begin
      flicker_status_irq_enable_next     = reg_wdata[SIP_FLICKER_EN_BIT];
      switch_matrix_done_irq_enable_next = reg_wdata[SIP_SENSOR_SWITCH_MATRIX_EN_BIT];
    end
    else if (reg_write && reg_addr == SIP_ADDR_PERSISTENCE)
      persistence_count_code_next = reg_wdata[SIP_CODE_MSB:0];
    rdata_next = 8'h00_00;
    if (reg_addr == SIP_ADDR_ENABLES)
    begin
      rdata_next[SIP_FLICKER_EN_BIT] = flicker_status_irq_enable_next;
      rdata_next[SIP_SENSOR_SWITCH_MATRIX_EN_BIT]    = switch_matrix_done_irq_enable_next;
    end
    else if (reg_addr == SIP_ADDR_PERSISTENCE)
      rdata_next[SIP_CODE_MSB:0] = persistence_count_code_next;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flicker_status_irq_enable_reg     <= SIP_ENABLES_RESET[SIP_FLICKER_EN_BIT];
      switch_matrix_done_irq_enable_reg <= SIP_ENABLES_RESET[SIP_SENSOR_SWITCH_MATRIX_EN_BIT];
      persistence_count_code_reg        <= SIP_CODE_RESET;
      rdata_reg                         <= 8'h00_00;
    end
    else
    begin
      flicker_status_irq_enable_reg     <= flicker_status_irq_enable_next;
      switch_matrix_done_irq_enable_reg <= switch_matrix_done_irq_enable_next;
      persistence_count_code_reg        <= persistence_count_code_next;
      rdata_reg                         <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // target count from the code
  logic [SIP_COUNT_W-1:0] target_count;
  sip_interrupt_persistence_map u_map
  (
    .code  (persistence_count_code_reg),
    .count (target_count)
  );

  // selected channel window compare; only that channel matters
  logic [SIP_DATA_W-1:0] selected_sample;
  logic                  outside_window;
  always_comb
  begin
    selected_sample = '0;
    if (32'(threshold_channel_select) < SIP_CHANNELS)
      selected_sample = spectral_data[threshold_channel_select*SIP_DATA_W +: SIP_DATA_W];
    outside_window = (selected_sample < spectral_low_threshold) ||
                     (selected_sample > spectral_high_threshold);
  end

  // persistence counter and one-cycle interrupt pulses
  sip_state_type          state_reg;
  sip_state_type          state_next;
  logic [SIP_COUNT_W-1:0] count_reg;
  logic [SIP_COUNT_W-1:0] count_next;
  logic                   spectral_irq_next;
  logic                   system_irq_next;
  always_comb
  begin
    state_next        = state_reg;
    count_next        = count_reg;
    spectral_irq_next = 1'b0;
    system_irq_next   = (flicker_status_change && flicker_status_irq_enable_reg) ||
                        (switch_matrix_done && switch_matrix_done_irq_enable_reg);
    if (spectral_cycle_end)
    begin
      case (state_reg)
        SIP_IDLE,
        SIP_COUNT:
        begin
          if (persistence_count_code_reg == 4'h0_0)
          begin
            spectral_irq_next = 1'b1;
            count_next        = '0;
            state_next        = SIP_IDLE;
          end
          else if (!outside_window)
          begin
            count_next = '0;
            state_next = SIP_IDLE;
          end
          else if (count_reg + 6'h00_01 >= target_count)
          begin
            spectral_irq_next = 1'b1;
            count_next        = '0;
            state_next        = SIP_IDLE;
          end
          else
          begin
            count_next = count_reg + 6'h00_01;
            state_next = SIP_COUNT;
          end
        end
        default:
          state_next = SIP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= SIP_IDLE;
      count_reg    <= '0;
      spectral_irq <= 1'b0;
      system_irq   <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      spectral_irq <= spectral_irq_next;
      system_irq   <= system_irq_next;
    end
  end
  assign persistence_count = count_reg;

  // checks
  chk_flicker_gate: assert property (@(posedge clock) disable iff (!rst_n)
    flicker_status_change && !switch_matrix_done |=> system_irq == $past(flicker_status_irq_enable_reg))
    else $error("flicker interrupt gating wrong");
  chk_sensor_switch_matrix_done: assert property (@(posedge clock) disable iff (!rst_n)
    switch_matrix_done && switch_matrix_done_irq_enable_reg |=> system_irq)
    else $error("switch matrix interrupt missing");
  chk_zero_code: assert property (@(posedge clock) disable iff (!rst_n)
    spectral_cycle_end && persistence_count_code_reg == 4'h0_0 |=> spectral_irq)
    else $error("code zero did not fire");
  chk_inside_clear: assert property (@(posedge clock) disable iff (!rst_n)
    spectral_cycle_end && !outside_window |=> count_reg == '0)
    else $error("in-window sample did not clear");
  chk_no_early: assert property (@(posedge clock) disable iff (!rst_n)
    spectral_irq && $past(persistence_count_code_reg) != 4'h0_0 |->
      $past(outside_window) && ($past(count_reg) + 6'h00_01 >= $past(target_count)))
    else $error("spectral interrupt before count");
  chk_restart: assert property (@(posedge clock) disable iff (!rst_n)
    spectral_irq |-> count_reg == '0)
    else $error("counter not restarted");
  chk_map_five: assert property (@(posedge clock) disable iff (!rst_n)
    persistence_count_code_reg == 4'h0_5 |-> target_count == 6'h00_0A)
    else $error("code five not ten");
  chk_map_top: assert property (@(posedge clock) disable iff (!rst_n)
    persistence_count_code_reg == 4'h0_F |-> target_count == 6'h00_3C)
    else $error("code fifteen not sixty");
  chk_select_used: assert property (@(posedge clock) disable iff (!rst_n)
    threshold_channel_select == 3'h0 |-> selected_sample == spectral_data[15:0])
    else $error("wrong channel compared");
  chk_quiet_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(spectral_cycle_end) |-> !spectral_irq)
    else $error("spectral interrupt without cycle end");
endmodule

// File: sip_pkg.sv
// constants of the spectral interrupt persistence block
package sip_pkg;
  localparam logic [7:0] SIP_ADDR_ENABLES     = 8'h00_B2;
  localparam logic [7:0] SIP_ADDR_PERSISTENCE = 8'h00_BD;
  localparam int         SIP_FLICKER_EN_BIT   = 6;
  localparam int         SIP_SENSOR_SWITCH_MATRIX_EN_BIT      = 4;
  localparam int         SIP_CODE_MSB         = 3;
  localparam logic [7:0] SIP_ENABLES_RESET    = 8'h00_00;
  localparam logic [3:0] SIP_CODE_RESET       = 4'h0_0;
  localparam int         SIP_COUNT_W          = 6;
  localparam int         SIP_CHANNELS         = 6;
  localparam int         SIP_SEL_W            = 3;
  localparam int         SIP_DATA_W           = 16;
  typedef enum logic [0:0]
  {
    SIP_IDLE  = 1'b0,
    SIP_COUNT = 1'b1
  } sip_state_type;
endpackage

// File: sip_interrupt_persistence_map.sv
// persistence code to consecutive count lookup
`timescale 1ns/1ps
module sip_interrupt_persistence_map
(
  input  wire logic [3:0] code,
  output logic      [5:0] count
);
  import sip_pkg::*;
  // codes 1..3 pass through, 4 is special, above is 5*(code-3)
  always_comb
  begin
    if (code <= 4'h0_3)
      count = {2'b00, code};
    else if (code == 4'h0_4)
      count = 6'h00_05;
    else
      // widen before the arithmetic so code 15 (60) cannot wrap in four bits
      count = ({2'b00, code} - 6'h00_03) * 6'h00_05;
  end
endmodule

// File: tb_top.sv
// self-checking bench for the interrupt enables and persistence filter
`timescale 1ns/1ps
module tb_top;
  import sip_pkg::*;
  logic                               clock = 1'b0;
  logic                               arst_n = 1'b0;
  logic                               reg_write = 1'b0;
  logic [7:0]                         reg_addr = 8'h00;
  logic [7:0]                         reg_wdata = 8'h00;
  logic [7:0]                         reg_rdata;
  logic                               flicker_status_change = 1'b0;
  logic                               switch_matrix_done = 1'b0;
  logic                               spectral_cycle_end = 1'b0;
  logic [SIP_CHANNELS*SIP_DATA_W-1:0] spectral_data = '0;
  logic [SIP_SEL_W-1:0]               threshold_channel_select = '0;
  logic [SIP_DATA_W-1:0]              spectral_low_threshold = 16'h0064;
  logic [SIP_DATA_W-1:0]              spectral_high_threshold = 16'h00C8;
  logic                               system_irq;
  logic                               spectral_irq;
  logic [SIP_COUNT_W-1:0]             persistence_count;
  int                                 n_errors = 0;
  int                                 total_checks = 0;
  int                                 tgt;

  sip_top DUT
  (
    .clock                    (clock),
    .arst_n                   (arst_n),
    .reg_write                (reg_write),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_rdata                (reg_rdata),
    .flicker_status_change    (flicker_status_change),
    .switch_matrix_done       (switch_matrix_done),
    .spectral_cycle_end       (spectral_cycle_end),
    .spectral_data            (spectral_data),
    .threshold_channel_select (threshold_channel_select),
    .spectral_low_threshold   (spectral_low_threshold),
    .spectral_high_threshold  (spectral_high_threshold),
    .system_irq               (system_irq),
    .spectral_irq             (spectral_irq),
    .persistence_count        (persistence_count)
  );

  // free-running 100 mhz clock
  initial
  begin
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic close_out;
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one-cycle write strobe, launched off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_write = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
    // idle cycle so the next call never re-raises the strobe in this time step
    @(negedge clock);
  endtask

  // read data is registered, so it is looked at one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    @(negedge clock);
    check(reg_rdata, exp);
  endtask

  // system events; both sources share one pulse output
  task automatic ev(input logic fl, input logic sm, input logic exp);
    flicker_status_change = fl;
    switch_matrix_done    = sm;
    @(negedge clock);
    flicker_status_change = 1'b0;
    switch_matrix_done    = 1'b0;
    check({7'h00, system_irq}, {7'h00, exp});
    @(negedge clock);
  endtask

  // unselected channels always carry the opposite verdict to catch a wrong select
  task automatic cyc(input logic outside, input logic exp);
    logic [SIP_CHANNELS*SIP_DATA_W-1:0] d;
    d = {SIP_CHANNELS{outside ? 16'h0096 : 16'h012C}};
    if (threshold_channel_select < SIP_CHANNELS)
      d[threshold_channel_select*16 +: 16] = outside ? 16'h012C : 16'h0096;
    spectral_data      = d;
    spectral_cycle_end = 1'b1;
    @(negedge clock);
    spectral_cycle_end = 1'b0;
    check({7'h00, spectral_irq}, {7'h00, exp});
    @(negedge clock);
  endtask

  // watchdog so a stuck run still reaches the verdict
  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end

  // main sequence
  initial
  begin
    repeat (3) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    rd(SIP_ADDR_ENABLES, 8'h00);
    rd(SIP_ADDR_PERSISTENCE, 8'h00);
    cyc(1'b0, 1'b1);
    cyc(1'b1, 1'b1);
    ev(1'b1, 1'b1, 1'b0);
    wr(SIP_ADDR_ENABLES, 8'hFF);
    wr(8'hB3, 8'h00);
    rd(SIP_ADDR_ENABLES, 8'h50);
    rd(8'hB3, 8'h00);
    wr(SIP_ADDR_ENABLES, 8'h10);
    ev(1'b1, 1'b0, 1'b0);
    ev(1'b0, 1'b1, 1'b1);
    wr(SIP_ADDR_ENABLES, 8'h40);
    ev(1'b0, 1'b1, 1'b0);
    ev(1'b1, 1'b0, 1'b1);
    // interrupted run: an in-window sample restarts the count
    wr(SIP_ADDR_PERSISTENCE, 8'h04);
    repeat (3) cyc(1'b1, 1'b0);
    check({2'b00, persistence_count}, 8'h03);
    cyc(1'b0, 1'b0);
    check({2'b00, persistence_count}, 8'h00);
    // every nonzero code, two full runs each
    for (int c = 1; c < 16; c++)
    begin
      threshold_channel_select = 3'(c % 6);
      wr(SIP_ADDR_PERSISTENCE, {4'hF, 4'(c)});
      rd(SIP_ADDR_PERSISTENCE, {4'h0, 4'(c)});
      tgt = (c <= 3) ? c : 5 * (c - 3);
      cyc(1'b0, 1'b0);
      for (int r = 0; r < 2; r++)
      begin
        for (int k = 1; k < tgt; k++) cyc(1'b1, 1'b0);
        cyc(1'b1, 1'b1);
        check({2'b00, persistence_count}, 8'h00);
      end
    end
    // selects past the last channel compare zero, which is below the low bound
    threshold_channel_select = 3'h7;
    wr(SIP_ADDR_PERSISTENCE, 8'h01);
    cyc(1'b0, 1'b1);
    // mid-run reset must drop the programmed enables and code
    arst_n = 1'b0;
    repeat (3) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    rd(SIP_ADDR_ENABLES, 8'h00);
    rd(SIP_ADDR_PERSISTENCE, 8'h00);
    ev(1'b1, 1'b1, 1'b0);
    cyc(1'b0, 1'b1);
    close_out();
  end
endmodule
